// file: rfcr_byte_lane.sv
`timescale 1ns/100ps
`default_nettype none
// one byte cell of the register space with its own reset value
module rfcr_byte_lane #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);
    typedef struct packed {
        logic [7:0] value;
    } rfcr_lane_state_t;

    rfcr_lane_state_t state_reg;
    rfcr_lane_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_en) begin
            state_next.value = wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{value: RESET_VALUE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.value;
endmodule : rfcr_byte_lane
`default_nettype wire

// file: rfcr_pkg.sv
package rfcr_pkg;

    // byte addresses of the byte-wide register space
    localparam logic [7:0] FIRST_FEC_ADDR      = 8'h14;
    localparam logic [7:0] SECOND_BASE_ADDR    = 8'h18;
    localparam logic [7:0] SECOND_MULT_ADDR    = 8'h1A;
    localparam logic [7:0] SECOND_FEC_ADDR     = 8'h1C;
    localparam logic [7:0] SPACE_FIRST_ADDR    = 8'h14;
    localparam logic [7:0] SPACE_LAST_ADDR     = 8'h1F;

    localparam logic [31:0] FEC_RATIO_RESET    = 32'h0001_0001;
    localparam logic [15:0] BASE_RATE_RESET    = 16'h9C40;
    localparam logic [15:0] RATE_MULT_RESET    = 16'h01E6;

    // field layout of a fec ratio word
    localparam int FEC_DEN_LSB = 0;
    localparam int FEC_NUM_LSB = 16;
    localparam int FIELD_W     = 16;

    // byte-space geometry
    localparam int NUM_BYTES   = 12;
    localparam int BYTE_W      = 8;

endpackage : rfcr_pkg

// file: rfcr_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - first input fec ratio: denominator in bits 15:0, numerator in 31:16
// - second input base rate is unsigned hertz value
// - wide registers big-endian: most significant byte at lowest address
// - second input multiple is unsigned factor on base rate
module rfcr_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [15:0]       first_input_fec_numerator,
    output logic      [15:0]       first_input_fec_denominator,
    output logic      [15:0]       base_rate_hz,
    output logic      [15:0]       base_rate_multiple,
    output logic      [15:0]       fec_numerator,
    output logic      [15:0]       fec_denominator,
    output logic      [47:0]       second_input_nominal_rate
);
    localparam int NB = rfcr_pkg::NUM_BYTES;
    localparam int BW = rfcr_pkg::BYTE_W;

    initial begin
        if (ADDR_W < 8) begin
            $error("rfcr_regs: ADDR_W must be at least 8");
        end
    end

    // reset image of the whole byte space, lowest address first
    localparam logic [NB*BW-1:0] RESET_IMAGE = {
        rfcr_pkg::FEC_RATIO_RESET,
        rfcr_pkg::BASE_RATE_RESET,
        rfcr_pkg::RATE_MULT_RESET,
        rfcr_pkg::FEC_RATIO_RESET};

    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } rfcr_bus_state_t;

    rfcr_bus_state_t state_reg;
    rfcr_bus_state_t state_next;

    logic [BW-1:0] byte_q  [NB];
    logic [NB-1:0] byte_we;
    logic [BW-1:0] byte_wd [NB];

    // word-aligned address maps to byte slots; also catches unmapped words
    function automatic logic word_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        word_hit = (w >= ADDR_W'(rfcr_pkg::SPACE_FIRST_ADDR))
                && (w <= ADDR_W'(rfcr_pkg::SPACE_LAST_ADDR));
    endfunction : word_hit

    function automatic int word_base(input logic [ADDR_W-1:0] a);
        word_base = int'({a[ADDR_W-1:2], 2'b00}) - int'(rfcr_pkg::SPACE_FIRST_ADDR);
    endfunction : word_base

    wire logic access = psel && penable;
    wire logic hit    = word_hit(paddr);

    // big-endian write: byte 0 of a word is bits 31:24
    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_byte
            localparam int LANE = 3 - (g % 4);
            assign byte_we[g] = access && pwrite && hit
                             && (word_base(paddr) == (g - (g % 4)))
                             && pstrb[LANE];
            assign byte_wd[g] = pwdata[LANE*BW +: BW];
            rfcr_byte_lane #(
                .RESET_VALUE(RESET_IMAGE[(NB-1-g)*BW +: BW])
            ) u_lane (
                .pclk   (pclk),
                .presetn(presetn),
                .wr_en  (byte_we[g]),
                .wr_data(byte_wd[g]),
                .q      (byte_q[g])
            );
        end
    endgenerate

    always_comb begin
        int b;
        b = 0;
        state_next = state_reg;
        if (psel && !penable) begin
            state_next.err   = !hit;
            state_next.rdata = '0;
            if (hit && !pwrite) begin
                b = word_base(paddr);
                state_next.rdata = {byte_q[b], byte_q[b+1], byte_q[b+2], byte_q[b+3]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // answer in the first access cycle; read data captured at setup
    assign pready  = 1'b1;
    assign prdata  = state_reg.rdata;
    assign pslverr = access && state_reg.err;

    // fec ratio split: numerator high, denominator low
    assign first_input_fec_numerator   = {byte_q[0], byte_q[1]};
    assign first_input_fec_denominator = {byte_q[2], byte_q[3]};
    assign base_rate_hz                = {byte_q[4], byte_q[5]};
    assign base_rate_multiple          = {byte_q[6], byte_q[7]};
    assign fec_numerator               = {byte_q[8], byte_q[9]};
    assign fec_denominator             = {byte_q[10], byte_q[11]};

    // nominal rate before fec scaling; registered so the product is clean
    logic [31:0] nominal_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nominal_reg <= '0;
        end else begin
            nominal_reg <= base_rate_hz * base_rate_multiple;
        end
    end
    assign second_input_nominal_rate = {16'h0000, nominal_reg};
endmodule : rfcr_regs
`default_nettype wire

// file: rfcr_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rfcr_regs_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic [15:0] first_input_fec_numerator,
    input wire logic [15:0] first_input_fec_denominator,
    input wire logic [15:0] base_rate_hz,
    input wire logic [15:0] base_rate_multiple,
    input wire logic [15:0] fec_numerator,
    input wire logic [15:0] fec_denominator
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite;
    ratio_split_a: assert property (wr && paddr == 8'h14 && pstrb == 4'hF |=>
        {first_input_fec_numerator, first_input_fec_denominator} == $past(pwdata))
        else $error("first ratio fields wrong");
    base_hertz_a: assert property (wr && paddr == 8'h18 && pstrb[3:2] == 2'h3 |=>
        base_rate_hz == $past(pwdata[31:16])) else $error("base rate wrong");
    mult_factor_a: assert property (wr && paddr[7:2] == 6'h06 && pstrb[1:0] == 2'h3 |=>
        base_rate_multiple == $past(pwdata[15:0])) else $error("multiple wrong");
    byte_order_a: assert property (wr && paddr == 8'h1C && pstrb == 4'h8 |=>
        fec_numerator[15:8] == $past(pwdata[31:24]) && $stable(fec_denominator))
        else $error("byte lane order wrong");
    read_order_a: assert property (psel && penable && !pwrite && paddr == 8'h1C |->
        prdata == {fec_numerator, fec_denominator}) else $error("read order wrong");
    cover property (wr && paddr == 8'h14);
    cover property (wr && pstrb == 4'h8);
    cover property (psel && penable && !pwrite && paddr == 8'h1C);
endmodule : rfcr_regs_assertions
bind rfcr_regs rfcr_regs_assertions u_chk (.*);
`default_nettype wire

// file: rfcr_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module rfcr_regs_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] first_input_fec_numerator, first_input_fec_denominator, base_rate_hz;
    logic [15:0] base_rate_multiple, fec_numerator, fec_denominator;
    logic [47:0] second_input_nominal_rate;
    int          error_cnt, n_tests;
    rfcr_regs u_dut (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // request held until the edge that sees pready; answer taken there
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let the write settle before callers look at the fields
        @(negedge pclk);
    endtask : xf
    task automatic t_fec;
        xf(1'b1, 8'h14, 32'h00FF_00ED, 4'hF);
        chk({first_input_fec_numerator, first_input_fec_denominator}, 32'h00FF_00ED);
        xf(1'b1, 8'h1C, 32'h41BE_3B80, 4'hF);
        xf(1'b0, 8'h1C, 32'h0, 4'h0);
        chk(rd, 32'h41BE_3B80);
        $display("t_fec done");
    endtask : t_fec
    task automatic t_bytes;
        xf(1'b1, 8'h18, 32'h6100_0000, 4'h8);
        chk({16'h0, base_rate_hz}, 32'h6140);
        xf(1'b1, 8'h1A, 32'hFFA8_186A, 4'h7);
        chk({base_rate_hz, base_rate_multiple}, 32'h61A8_186A);
        xf(1'b1, 8'h1C, 32'h00FF_FFFF, 4'h8);
        chk({fec_numerator, fec_denominator}, 32'h00BE_3B80);
        $display("t_bytes done");
    endtask : t_bytes
    task automatic t_misc;
        xf(1'b0, 8'h18, 32'h0, 4'h0);
        chk(rd, 32'h9C40_01E6);
        chk({31'h0, er}, 32'h0);
        chk({fec_numerator, fec_denominator}, 32'h0001_0001);
        chk(second_input_nominal_rate[31:0], 32'h0128_A180);
        chk({16'h0, second_input_nominal_rate[47:32]}, 32'h0);
        xf(1'b1, 8'h30, 32'h1234_5678, 4'hF);
        chk({31'h0, er}, 32'h1);
        $display("t_misc done");
    endtask : t_misc
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #20000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_misc();
        t_fec();
        t_bytes();
        end_of_test();
    end
endmodule : rfcr_regs_tb_top
`default_nettype wire
